//--- include/pgcb_pkg.sv
// Package with register map, field positions and timing constants of the gauge config bank
package pgcb_pkg;
	// Register indices, printed offsets are index, byte address is four times
	localparam logic [7:0] IDX_PACK = 8'h28;
	localparam logic [7:0] IDX_GAUGE = 8'h29;
	localparam logic [7:0] IDX_MISC = 8'h2A;
	localparam logic [7:0] IDX_CELL_HI = 8'h60;
	localparam logic [7:0] IDX_CELL_LO = 8'h62;
	localparam logic [7:0] IDX_SAFE_V = 8'h68;
	localparam logic [7:0] IDX_SAFE_T = 8'h6A;
	localparam logic [7:0] IDX_FE_BROWN = 8'hB1;
	localparam logic [7:0] IDX_FE_DOC = 8'hB2;
	localparam logic [7:0] IDX_FE_COC = 8'hB3;
	localparam logic [7:0] IDX_FE_OCD = 8'hB4;
	localparam logic [7:0] IDX_FE_SHORT = 8'hB6;
	localparam logic [7:0] IDX_FE_SHD = 8'hB7;
	localparam logic [7:0] IDX_CELL_LO_REL = 8'hD1;
	localparam logic [7:0] IDX_CHECK_PER = 8'hE4;
	localparam logic [7:0] IDX_SLEEP_CUR = 8'hE5;
	localparam logic [7:0] IDX_SLEEP_WAKE = 8'hE6;
	localparam logic [7:0] IDX_CELL_HI_REL = 8'hEF;
	// Own registers: status, fail limit and termination percent
	localparam logic [7:0] IDX_STATUS = 8'hF0;
	localparam logic [7:0] IDX_FAIL_LIMIT = 8'hF1;
	localparam logic [7:0] IDX_TERM_PCT = 8'hF2;
	// Pack byte fields
	localparam int PK_DISPLAY = 7;
	localparam int PK_SEG_HI = 6;
	localparam int PK_SEG_LO = 5;
	localparam int PK_HOST_PEC = 4;
	localparam int PK_CHG_PEC = 3;
	localparam int PK_SUPPRESS = 2;
	localparam int PK_CELL_HI = 1;
	localparam int PK_CELL_LO = 0;
	// Gauge byte fields
	localparam int GA_RESV = 7;
	localparam int GA_SYNC = 6;
	localparam int GA_CHGTYPE = 5;
	localparam int GA_COMP = 4;
	localparam int GA_VBASIS = 3;
	localparam int GA_SBASIS = 2;
	localparam int GA_CONT = 1;
	localparam int GA_ONESHOT = 0;
	// Misc byte fields
	localparam int MI_INTSENS = 7;
	localparam int MI_RESV = 6;
	localparam int MI_INTEG = 5;
	localparam int MI_SLEEPDIS = 4;
	localparam int MI_OTDSG = 3;
	localparam int MI_CHGLED = 2;
	localparam int MI_PRECHG = 1;
	localparam int MI_FETDLY = 0;
	// Reset values of the config bytes
	localparam logic [7:0] RST_PACK = 8'h00;
	localparam logic [7:0] RST_GAUGE = 8'h40;
	localparam logic [7:0] RST_MISC = 8'h00;
	localparam logic [15:0] RST_FAIL_LIMIT = 16'hFFFF;
	localparam logic [7:0] RST_TERM_PCT = 8'hFF;
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int SLEEP_MS = 2000;
	localparam int FET_DELAY_MS = 1000;
	localparam int SLEEP_CYC = SLEEP_MS * (CLK_HZ / 1000);
	localparam int FET_DELAY_CYC = FET_DELAY_MS * (CLK_HZ / 1000);
	localparam int SEC_CYC = CLK_HZ;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pgcb_pkg

//--- hdl/pgcb_top.sv
// Gauge configuration bank: AXI4-Lite registers and the control decisions they steer
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pgcb_top #(
	parameter int SLEEP_CYCLES = pgcb_pkg::SLEEP_CYC,
	parameter int FET_DELAY_CYCLES = pgcb_pkg::FET_DELAY_CYC,
	parameter int SECOND_CYCLES = pgcb_pkg::SEC_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [11:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic DISCHARGING,
	input wire logic SMB_CLK_IN,
	input wire logic SMB_DATA_IN,
	input wire logic OVERTEMP,
	input wire logic FET_CHG_REQ,
	input wire logic FET_DSG_REQ,
	input wire logic MODE_BCAST_EN,
	input wire logic CHARGE_TERM,
	input wire logic CHECK_FAIL,
	input wire logic [15:0] FULL_CAP,
	output logic LED_RELATIVE,
	output logic [2:0] LED_SEGMENTS,
	output logic LED_ENABLE,
	output logic HOST_PEC_EN,
	output logic CHG_PEC_EN,
	output logic BCAST_EN,
	output logic [2:0] SERIES_CELLS,
	output logic CAP_LOAD,
	output logic [15:0] CAP_LOAD_VALUE,
	output logic LEARN_INDEP,
	output logic EOD_COMPUTED,
	output logic EOD_PACK_BASIS,
	output logic SAFE_CELL_BASIS,
	output logic CORR_CONT,
	output logic CORR_ONCE,
	output logic CHECK_TICK,
	output logic FAIL_FLAG,
	output logic SAFE_OUT,
	output logic SLEEP,
	output logic CHG_FET_ON,
	output logic DSG_FET_ON,
	output logic INT_SENSOR,
	output logic PRECHG_CTRL,
	output logic [7:0] CELL_HIGH_RELEASE,
	output logic [15:0] CELL_LOW_LIMIT,
	output logic [15:0] CELL_HIGH_LIMIT,
	output logic [15:0] SAFETY_VOLT,
	output logic [15:0] SAFETY_TEMP_DC
);
	typedef struct packed {
		logic aw_done;
		logic w_done;
		logic [7:0] widx;
		logic [31:0] wdat;
		logic [3:0] wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] pack;
		logic [7:0] gauge;
		logic [7:0] misc;
		logic [15:0] cell_hi;
		logic [15:0] cell_lo;
		logic [15:0] safe_v;
		logic [15:0] safe_t;
		logic [5:0][7:0] fe;
		logic [15:0] cell_lo_rel;
		logic [7:0] cell_hi_rel;
		logic [7:0] chk_per;
		logic [7:0] slp_cur;
		logic [7:0] slp_wake;
		logic [15:0] fail_lim;
		logic [7:0] term_pct;
		logic [15:0] fail_cnt;
		logic fail_flag;
		logic oneshot_pend;
		logic [31:0] sec_cnt;
		logic [7:0] sec_left;
		logic [31:0] idle_cnt;
		logic sleep;
		logic chg_fet;
		logic dsg_fet;
		logic [31:0] chg_dly;
		logic [31:0] dsg_dly;
		logic cap_load;
		logic [15:0] cap_val;
	} pgcb_state_t;

	pgcb_state_t s_q, s_d;

	// Map a register index onto a fixed 32-bit read word; unknown index flags an error
	function automatic logic [32:0] pgcb_read(input pgcb_state_t s, input logic [7:0] idx);
		logic [32:0] r;
		r = {1'b0, 32'h0000_0000};
		case (idx)
			pgcb_pkg::IDX_PACK: r[7:0] = s.pack;
			pgcb_pkg::IDX_GAUGE: r[7:0] = s.gauge;
			pgcb_pkg::IDX_MISC: r[7:0] = s.misc;
			pgcb_pkg::IDX_CELL_HI: r[15:0] = s.cell_hi;
			pgcb_pkg::IDX_CELL_LO: r[15:0] = s.cell_lo;
			pgcb_pkg::IDX_SAFE_V: r[15:0] = s.safe_v;
			pgcb_pkg::IDX_SAFE_T: r[15:0] = s.safe_t;
			pgcb_pkg::IDX_FE_BROWN: r[7:0] = s.fe[0];
			pgcb_pkg::IDX_FE_DOC: r[7:0] = s.fe[1];
			pgcb_pkg::IDX_FE_COC: r[7:0] = s.fe[2];
			pgcb_pkg::IDX_FE_OCD: r[7:0] = s.fe[3];
			pgcb_pkg::IDX_FE_SHORT: r[7:0] = s.fe[4];
			pgcb_pkg::IDX_FE_SHD: r[7:0] = s.fe[5];
			pgcb_pkg::IDX_CELL_LO_REL: r[15:0] = s.cell_lo_rel;
			pgcb_pkg::IDX_CHECK_PER: r[7:0] = s.chk_per;
			pgcb_pkg::IDX_SLEEP_CUR: r[7:0] = s.slp_cur;
			pgcb_pkg::IDX_SLEEP_WAKE: r[7:0] = s.slp_wake;
			pgcb_pkg::IDX_CELL_HI_REL: r[7:0] = s.cell_hi_rel;
			pgcb_pkg::IDX_STATUS: r[3:0] = {s.chg_fet, s.dsg_fet, s.sleep, s.fail_flag};
			pgcb_pkg::IDX_FAIL_LIMIT: r[15:0] = s.fail_lim;
			pgcb_pkg::IDX_TERM_PCT: r[7:0] = s.term_pct;
			default: r[32] = 1'b1;
		endcase
		return r;
	endfunction : pgcb_read

	// Byte-lane merge for 8 and 16 bit registers
	function automatic logic [15:0] pgcb_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] stb);
		logic [15:0] m;
		m = old;
		if (stb[0]) begin
			m[7:0] = d[7:0];
		end
		if (stb[1]) begin
			m[15:8] = d[15:8];
		end
		return m;
	endfunction : pgcb_merge

	logic [32:0] rd_word;
	logic [32:0] wr_check;
	logic wr_fire;
	logic [15:0] pct_prod;

	// Handshake readies are combinational: accept while no answer is pending
	assign AWREADY = !s_q.aw_done && !s_q.bvalid;
	assign WREADY = !s_q.w_done && !s_q.bvalid;
	assign ARREADY = !s_q.rvalid;
	assign rd_word = pgcb_read(s_q, ARADDR[9:2]);
	assign wr_fire = s_q.aw_done && s_q.w_done;
	assign wr_check = pgcb_read(s_q, s_q.widx);
	assign pct_prod = 16'((32'(FULL_CAP) * (32'(s_q.term_pct) + 32'd1)) >> 8);

	always_comb begin
		s_d = s_q;
		s_d.cap_load = 1'b0;
		// Address and data are caught in either order
		if (AWVALID && AWREADY) begin
			s_d.aw_done = 1'b1;
			s_d.widx = AWADDR[9:2];
		end
		if (WVALID && WREADY) begin
			s_d.w_done = 1'b1;
			s_d.wdat = WDATA;
			s_d.wstb = WSTRB;
		end
		if (wr_fire) begin
			s_d.aw_done = 1'b0;
			s_d.w_done = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_check[32] ? pgcb_pkg::RESP_SLVERR : pgcb_pkg::RESP_OKAY;
			case (s_q.widx)
				pgcb_pkg::IDX_PACK: s_d.pack = 8'(pgcb_merge({8'h00, s_q.pack}, s_q.wdat, s_q.wstb));
				pgcb_pkg::IDX_GAUGE: begin
					s_d.gauge = 8'(pgcb_merge({8'h00, s_q.gauge}, s_q.wdat, s_q.wstb));
					s_d.gauge[pgcb_pkg::GA_RESV] = 1'b0;
				end
				pgcb_pkg::IDX_MISC: begin
					s_d.misc = 8'(pgcb_merge({8'h00, s_q.misc}, s_q.wdat, s_q.wstb));
					s_d.misc[pgcb_pkg::MI_RESV] = 1'b0;
				end
				pgcb_pkg::IDX_CELL_HI: s_d.cell_hi = pgcb_merge(s_q.cell_hi, s_q.wdat, s_q.wstb);
				pgcb_pkg::IDX_CELL_LO: s_d.cell_lo = pgcb_merge(s_q.cell_lo, s_q.wdat, s_q.wstb);
				pgcb_pkg::IDX_SAFE_V: s_d.safe_v = pgcb_merge(s_q.safe_v, s_q.wdat, s_q.wstb);
				pgcb_pkg::IDX_SAFE_T: s_d.safe_t = pgcb_merge(s_q.safe_t, s_q.wdat, s_q.wstb);
				pgcb_pkg::IDX_FE_BROWN: s_d.fe[0] = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.fe[0];
				pgcb_pkg::IDX_FE_DOC: s_d.fe[1] = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.fe[1];
				pgcb_pkg::IDX_FE_COC: s_d.fe[2] = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.fe[2];
				pgcb_pkg::IDX_FE_OCD: s_d.fe[3] = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.fe[3];
				pgcb_pkg::IDX_FE_SHORT: s_d.fe[4] = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.fe[4];
				pgcb_pkg::IDX_FE_SHD: s_d.fe[5] = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.fe[5];
				pgcb_pkg::IDX_CELL_LO_REL: begin
					s_d.cell_lo_rel = pgcb_merge(s_q.cell_lo_rel, s_q.wdat, s_q.wstb);
				end
				pgcb_pkg::IDX_CHECK_PER: s_d.chk_per = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.chk_per;
				pgcb_pkg::IDX_SLEEP_CUR: s_d.slp_cur = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.slp_cur;
				pgcb_pkg::IDX_SLEEP_WAKE: begin
					s_d.slp_wake = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.slp_wake;
				end
				pgcb_pkg::IDX_CELL_HI_REL: begin
					s_d.cell_hi_rel = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.cell_hi_rel;
				end
				pgcb_pkg::IDX_FAIL_LIMIT: s_d.fail_lim = pgcb_merge(s_q.fail_lim, s_q.wdat, s_q.wstb);
				pgcb_pkg::IDX_TERM_PCT: s_d.term_pct = s_q.wstb[0] ? s_q.wdat[7:0] : s_q.term_pct;
				default: s_d.bresp = pgcb_pkg::RESP_SLVERR;
			endcase
		end
		if (s_q.bvalid && BREADY) begin
			s_d.bvalid = 1'b0;
		end
		// Read answer one cycle after the address is taken
		if (ARVALID && ARREADY) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_word[31:0];
			s_d.rresp = rd_word[32] ? pgcb_pkg::RESP_SLVERR : pgcb_pkg::RESP_OKAY;
		end else if (s_q.rvalid && RREADY) begin
			s_d.rvalid = 1'b0;
		end
		// periodic integrity check, period in seconds
		s_d.sec_cnt = s_q.sec_cnt + 32'd1;
		if (s_q.sec_cnt >= 32'(SECOND_CYCLES - 1)) begin
			s_d.sec_cnt = 32'd0;
			s_d.sec_left = (s_q.sec_left <= 8'h01) ? s_q.chk_per : s_q.sec_left - 8'h01;
		end
		if (CHECK_TICK && CHECK_FAIL && !s_q.fail_flag) begin
			s_d.fail_cnt = s_q.fail_cnt + 16'h0001;
			if (s_d.fail_cnt >= s_q.fail_lim) begin
				s_d.fail_flag = 1'b1;
			end
		end
		if (CHARGE_TERM && s_q.gauge[pgcb_pkg::GA_SYNC]) begin
			s_d.cap_load = 1'b1;
			s_d.cap_val = pct_prod;
		end
		// single correction after reset; pending until the bit allows it, since the gauge
		// byte resets to 40h with the one-shot bit clear and software sets the bit only after reset
		if (s_q.oneshot_pend && s_q.gauge[pgcb_pkg::GA_ONESHOT]) begin
			s_d.oneshot_pend = 1'b0;
		end
		// sleep after both lines low for the timeout
		if (SMB_CLK_IN || SMB_DATA_IN || s_q.misc[pgcb_pkg::MI_SLEEPDIS]) begin
			s_d.idle_cnt = 32'd0;
			s_d.sleep = 1'b0;
		end else if (s_q.idle_cnt >= 32'(SLEEP_CYCLES - 1)) begin
			s_d.sleep = 1'b1;
		end else begin
			s_d.idle_cnt = s_q.idle_cnt + 32'd1;
		end
		// overtemp opens the charge FET, and the discharge FET only when OTDSG is set; optional one-second change delay
		if ((FET_CHG_REQ && !OVERTEMP) != s_q.chg_fet) begin
			s_d.chg_dly = s_q.chg_dly + 32'd1;
			if (!s_q.misc[pgcb_pkg::MI_FETDLY] || s_q.chg_dly >= 32'(FET_DELAY_CYCLES - 1)) begin
				s_d.chg_fet = !s_q.chg_fet;
				s_d.chg_dly = 32'd0;
			end
		end else begin
			s_d.chg_dly = 32'd0;
		end
		if ((FET_DSG_REQ && !(OVERTEMP && s_q.misc[pgcb_pkg::MI_OTDSG])) != s_q.dsg_fet) begin
			s_d.dsg_dly = s_q.dsg_dly + 32'd1;
			if (!s_q.misc[pgcb_pkg::MI_FETDLY] || s_q.dsg_dly >= 32'(FET_DELAY_CYCLES - 1)) begin
				s_d.dsg_fet = !s_q.dsg_fet;
				s_d.dsg_dly = 32'd0;
			end
		end else begin
			s_d.dsg_dly = 32'd0;
		end
	end

	// State register; config bytes take their stored defaults at reset
	always_ff @(posedge CLK) begin
		if (RST) begin
			s_q <= '0;
			s_q.pack <= pgcb_pkg::RST_PACK;
			s_q.gauge <= pgcb_pkg::RST_GAUGE;
			s_q.misc <= pgcb_pkg::RST_MISC;
			s_q.fail_lim <= pgcb_pkg::RST_FAIL_LIMIT;
			s_q.term_pct <= pgcb_pkg::RST_TERM_PCT;
			s_q.oneshot_pend <= 1'b1;
			s_q.sec_left <= 8'h01;
		end else begin
			s_q <= s_d;
		end
	end

	// Bus outputs straight from state
	assign BVALID = s_q.bvalid;
	assign BRESP = s_q.bresp;
	assign RVALID = s_q.rvalid;
	assign RDATA = s_q.rdata;
	assign RRESP = s_q.rresp;

	assign LED_RELATIVE = s_q.pack[pgcb_pkg::PK_DISPLAY];
	assign LED_SEGMENTS = (s_q.pack[pgcb_pkg::PK_SEG_HI:pgcb_pkg::PK_SEG_LO] == 2'b01) ? 3'd3 :
		(s_q.pack[pgcb_pkg::PK_SEG_HI:pgcb_pkg::PK_SEG_LO] == 2'b10) ? 3'd4 : 3'd5;
	assign LED_ENABLE = DISCHARGING || s_q.misc[pgcb_pkg::MI_CHGLED];
	assign HOST_PEC_EN = s_q.pack[pgcb_pkg::PK_HOST_PEC];
	assign CHG_PEC_EN = s_q.pack[pgcb_pkg::PK_CHG_PEC];
	assign BCAST_EN = MODE_BCAST_EN && !s_q.pack[pgcb_pkg::PK_SUPPRESS];
	// cell count, other codes default to three
	assign SERIES_CELLS = (s_q.pack[pgcb_pkg::PK_CELL_HI:pgcb_pkg::PK_CELL_LO] == 2'b11) ?
		3'd4 : 3'd3;
	assign CAP_LOAD = s_q.cap_load;
	assign CAP_LOAD_VALUE = s_q.cap_val;
	assign LEARN_INDEP = s_q.gauge[pgcb_pkg::GA_CHGTYPE];
	assign EOD_COMPUTED = s_q.gauge[pgcb_pkg::GA_COMP];
	assign EOD_PACK_BASIS = s_q.gauge[pgcb_pkg::GA_VBASIS];
	assign SAFE_CELL_BASIS = s_q.gauge[pgcb_pkg::GA_SBASIS];
	assign CORR_CONT = s_q.gauge[pgcb_pkg::GA_CONT];
	assign CORR_ONCE = s_q.oneshot_pend && s_q.gauge[pgcb_pkg::GA_ONESHOT];
	assign CHECK_TICK = (s_q.sec_cnt >= 32'(SECOND_CYCLES - 1)) && (s_q.sec_left <= 8'h01)
		&& (s_q.chk_per != 8'h00);
	assign FAIL_FLAG = s_q.fail_flag;
	assign SAFE_OUT = s_q.fail_flag && s_q.misc[pgcb_pkg::MI_INTEG];
	assign SLEEP = s_q.sleep;
	assign CHG_FET_ON = s_q.chg_fet;
	assign DSG_FET_ON = s_q.dsg_fet;
	assign INT_SENSOR = s_q.misc[pgcb_pkg::MI_INTSENS];
	assign PRECHG_CTRL = s_q.misc[pgcb_pkg::MI_PRECHG];
	assign CELL_HIGH_RELEASE = s_q.cell_hi_rel;
	assign CELL_LOW_LIMIT = s_q.cell_lo;
	assign CELL_HIGH_LIMIT = s_q.cell_hi;
	assign SAFETY_VOLT = s_q.safe_v;
	assign SAFETY_TEMP_DC = s_q.safe_t;

	// Assertions
	chk_bcast_suppress: assert property (@(posedge CLK) disable iff (RST)
		s_q.pack[pgcb_pkg::PK_SUPPRESS] |-> !BCAST_EN) else $error("broadcast while suppressed");
	chk_bcast_on: assert property (@(posedge CLK) disable iff (RST)
		(MODE_BCAST_EN && !s_q.pack[pgcb_pkg::PK_SUPPRESS]) |-> BCAST_EN)
		else $error("broadcast missing");
	chk_seg_three: assert property (@(posedge CLK) disable iff (RST)
		(s_q.pack[pgcb_pkg::PK_SEG_HI:pgcb_pkg::PK_SEG_LO] == 2'b01) |-> LED_SEGMENTS == 3'd3)
		else $error("segment decode");
	chk_cell_four: assert property (@(posedge CLK) disable iff (RST)
		(s_q.pack[pgcb_pkg::PK_CELL_HI:pgcb_pkg::PK_CELL_LO] == 2'b11) |-> SERIES_CELLS == 3'd4)
		else $error("cell decode");
	chk_once_single: assert property (@(posedge CLK) disable iff (RST)
		CORR_ONCE |=> !CORR_ONCE) else $error("second one-shot correction");
	chk_chg_led: assert property (@(posedge CLK) disable iff (RST)
		(!DISCHARGING && !s_q.misc[pgcb_pkg::MI_CHGLED]) |-> !LED_ENABLE) else $error("led on");
	chk_sync_load: assert property (@(posedge CLK) disable iff (RST)
		(CHARGE_TERM && s_q.gauge[pgcb_pkg::GA_SYNC]) |=> CAP_LOAD) else $error("no load");
	chk_sync_off: assert property (@(posedge CLK) disable iff (RST)
		(!CHARGE_TERM || !s_q.gauge[pgcb_pkg::GA_SYNC]) |=> !CAP_LOAD) else $error("bad load");
	chk_ot_charge: assert property (@(posedge CLK) disable iff (RST)
		(OVERTEMP && !s_q.misc[pgcb_pkg::MI_FETDLY]) [*2] |-> !CHG_FET_ON)
		else $error("charge fet on in overtemp");
	chk_safe_out: assert property (@(posedge CLK) disable iff (RST)
		SAFE_OUT |-> (FAIL_FLAG && s_q.misc[pgcb_pkg::MI_INTEG])) else $error("safe out");
	chk_gauge_resv: assert property (@(posedge CLK) disable iff (RST)
		!s_q.gauge[pgcb_pkg::GA_RESV]) else $error("reserved bit set");
	chk_sleep_dis: assert property (@(posedge CLK) disable iff (RST)
		s_q.misc[pgcb_pkg::MI_SLEEPDIS] |=> !SLEEP) else $error("sleep when disabled");
	cov_write: cover property (@(posedge CLK) disable iff (RST) BVALID && BREADY);
	cov_read: cover property (@(posedge CLK) disable iff (RST) RVALID && RREADY);
	cov_load: cover property (@(posedge CLK) disable iff (RST) CAP_LOAD);
	cov_once: cover property (@(posedge CLK) disable iff (RST) CORR_ONCE);
endmodule : pgcb_top

//--- tb/pgcb_smb_model.sv
// Bus host stand-in: both bus lines float high by pull-up unless the host holds them low
`timescale 1ns/1ps
module pgcb_smb_model (
	input wire logic CLK,
	input wire logic hold_low,
	output logic smb_clk,
	output logic smb_data
);
	// Released lines show the pull-up level, never the last driven value
	always_ff @(posedge CLK) begin
		smb_clk <= !hold_low;
		smb_data <= !hold_low;
	end
endmodule : pgcb_smb_model

//--- tb/testbench.sv
// Self-checking bench for the gauge configuration bank
`timescale 1ns/1ps
module testbench;
	logic CLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
	logic [31:0] WDATA = 32'h0, RDATA;
	logic [3:0] WSTRB = 4'h0;
	logic [1:0] BRESP, RRESP, rsp;
	logic DISCHARGING = 1, OVERTEMP = 0, FET_CHG_REQ = 0, FET_DSG_REQ = 0, MODE_BCAST_EN = 1;
	logic CHARGE_TERM = 0, CHECK_FAIL = 0, hold = 0, SMB_CLK_IN, SMB_DATA_IN;
	logic [15:0] FULL_CAP = 16'h1000, CAP_LOAD_VALUE, CELL_LOW_LIMIT, CELL_HIGH_LIMIT;
	logic [15:0] SAFETY_VOLT, SAFETY_TEMP_DC;
	logic [7:0] CELL_HIGH_RELEASE;
	logic [2:0] LED_SEGMENTS, SERIES_CELLS;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, LED_RELATIVE, LED_ENABLE, HOST_PEC_EN;
	logic CHG_PEC_EN, BCAST_EN, CAP_LOAD, LEARN_INDEP, EOD_COMPUTED, EOD_PACK_BASIS;
	logic SAFE_CELL_BASIS, CORR_CONT, CORR_ONCE, CHECK_TICK, FAIL_FLAG, SAFE_OUT, SLEEP;
	logic CHG_FET_ON, DSG_FET_ON, INT_SENSOR, PRECHG_CTRL;
	logic [31:0] rd;
	int n_errors = 0, n_checks = 0, n_once = 0, n_tick = 0;
	// Short counts keep the run brief
	pgcb_top #(.SLEEP_CYCLES(20), .FET_DELAY_CYCLES(10), .SECOND_CYCLES(5)) pgcb_top_inst (
		.CLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
		.BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
		.DISCHARGING, .SMB_CLK_IN, .SMB_DATA_IN, .OVERTEMP, .FET_CHG_REQ, .FET_DSG_REQ,
		.MODE_BCAST_EN, .CHARGE_TERM, .CHECK_FAIL, .FULL_CAP, .LED_RELATIVE, .LED_SEGMENTS,
		.LED_ENABLE, .HOST_PEC_EN, .CHG_PEC_EN, .BCAST_EN, .SERIES_CELLS, .CAP_LOAD,
		.CAP_LOAD_VALUE, .LEARN_INDEP, .EOD_COMPUTED, .EOD_PACK_BASIS, .SAFE_CELL_BASIS,
		.CORR_CONT, .CORR_ONCE, .CHECK_TICK, .FAIL_FLAG, .SAFE_OUT, .SLEEP, .CHG_FET_ON,
		.DSG_FET_ON, .INT_SENSOR, .PRECHG_CTRL, .CELL_HIGH_RELEASE, .CELL_LOW_LIMIT,
		.CELL_HIGH_LIMIT, .SAFETY_VOLT, .SAFETY_TEMP_DC);
	pgcb_smb_model pgcb_smb_model_inst (.CLK, .hold_low(hold), .smb_clk(SMB_CLK_IN),
		.smb_data(SMB_DATA_IN));
	initial begin
		forever #12.5 CLK = ~CLK;
	end
	// Pulse counters: one-cycle outputs are easy to miss from inside a bus task
	always @(posedge CLK) begin
		if (CORR_ONCE === 1'b1) n_once <= n_once + 1;
		if (CHECK_TICK === 1'b1) n_tick <= n_tick + 1;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic hang(input string nm);
		n_errors++;
		$display("mismatch %s expected answer seen none", nm);
		test_done();
	endtask : hang
	// Readies are sampled at the falling edge, where nothing the bench drives is moving
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic a, w, b;
		b = 0;
		@(posedge CLK);
		AWADDR <= {2'h0, idx, 2'h0};
		WDATA <= d;
		WSTRB <= 4'hF;
		AWVALID <= 1;
		WVALID <= 1;
		BREADY <= 1;
		for (int i = 0; i < 50 && !b; i++) begin
			@(negedge CLK);
			a = AWVALID && AWREADY;
			w = WVALID && WREADY;
			b = BVALID === 1'b1;
			rsp = BRESP;
			@(posedge CLK);
			if (a) AWVALID <= 0;
			if (w) WVALID <= 0;
			if (b) BREADY <= 0;
		end
		if (!b) hang("write answer");
	endtask : wr
	task automatic rdr(input logic [7:0] idx);
		logic a, b;
		b = 0;
		@(posedge CLK);
		ARADDR <= {2'h0, idx, 2'h0};
		ARVALID <= 1;
		RREADY <= 1;
		for (int i = 0; i < 50 && !b; i++) begin
			@(negedge CLK);
			a = ARVALID && ARREADY;
			b = RVALID === 1'b1;
			rsp = RRESP;
			rd = RDATA;
			@(posedge CLK);
			if (a) ARVALID <= 0;
			if (b) RREADY <= 0;
		end
		if (!b) hang("read answer");
	endtask : rdr
	task automatic cyc(input int k);
		repeat (k) @(negedge CLK);
	endtask : cyc
	task automatic t_reset;
		rdr(pgcb_pkg::IDX_GAUGE); chk("gauge", 32'h40, rd);
		rdr(pgcb_pkg::IDX_PACK); chk("pack", 32'h0, rd);
		rdr(8'h00); chk("unmapped", pgcb_pkg::RESP_SLVERR, rsp);
		wr(8'h01, 32'h5A); chk("unmapped wr", pgcb_pkg::RESP_SLVERR, rsp);
		chk("no once at reset", 0, n_once);
		$display("test reset done");
	endtask : t_reset
	// every segment code with display, PEC and cell fields
	task automatic t_pack;
		logic [2:0] seg;
		for (int i = 0; i < 4; i++) begin
			wr(pgcb_pkg::IDX_PACK, {24'h0, i[0], i[1:0], i[0], ~i[0], 1'b0, 1'b1, i[1]});
			seg = (i == 1) ? 3'd3 : (i == 2) ? 3'd4 : 3'd5;
			cyc(2);
			chk("segments", seg, LED_SEGMENTS);
			chk("relative", i[0], LED_RELATIVE);
			chk("host pec", i[0], HOST_PEC_EN);
			chk("chg pec", {~i[0]}, CHG_PEC_EN);
			chk("cells", i[1] ? 3'd4 : 3'd3, SERIES_CELLS);
		end
		$display("test pack done");
	endtask : t_pack
	task automatic t_bcast;
		wr(pgcb_pkg::IDX_PACK, 32'h04);
		@(posedge CLK) MODE_BCAST_EN <= 0;
		@(posedge CLK) MODE_BCAST_EN <= 1;
		cyc(2); chk("bcast suppressed", 0, BCAST_EN);
		wr(pgcb_pkg::IDX_PACK, 32'h00);
		cyc(2); chk("bcast on", 1, BCAST_EN);
		$display("test bcast done");
	endtask : t_bcast
	task automatic t_gauge;
		wr(pgcb_pkg::IDX_TERM_PCT, 32'h7F);
		@(posedge CLK) CHARGE_TERM <= 1;
		@(posedge CLK) CHARGE_TERM <= 0;
		for (int i = 0; i < 5 && CAP_LOAD !== 1'b1; i++) cyc(1);
		chk("cap load", 1, CAP_LOAD);
		chk("cap value", 16'h0800, CAP_LOAD_VALUE);
		wr(pgcb_pkg::IDX_GAUGE, 32'hBF);
		rdr(pgcb_pkg::IDX_GAUGE); chk("gauge rsv", 32'h3F, rd);
		chk("flags", 5'h1F, {LEARN_INDEP, EOD_COMPUTED, EOD_PACK_BASIS, SAFE_CELL_BASIS,
			CORR_CONT});
		@(posedge CLK) CHARGE_TERM <= 1;
		@(posedge CLK) CHARGE_TERM <= 0;
		for (int i = 0; i < 5; i++) begin
			cyc(1); chk("no load", 0, CAP_LOAD);
		end
		chk("once", 1, n_once);
		$display("test gauge done");
	endtask : t_gauge
	// limits reach their outputs; cell low limit reads back
	task automatic t_limits;
		wr(pgcb_pkg::IDX_CELL_LO, 32'h0BB8);
		wr(pgcb_pkg::IDX_SAFE_T, 32'h0259);
		cyc(2); chk("cell low", 16'h0BB8, CELL_LOW_LIMIT);
		chk("safe temp", 16'h0259, SAFETY_TEMP_DC);
		rdr(pgcb_pkg::IDX_CELL_LO); chk("cell low rd", 32'h0BB8, rd);
		wr(pgcb_pkg::IDX_CELL_HI, 32'h1068);
		wr(pgcb_pkg::IDX_SAFE_V, 32'h4268);
		wr(pgcb_pkg::IDX_CELL_HI_REL, 32'h64);
		wr(pgcb_pkg::IDX_MISC, 32'hC2);
		cyc(2); chk("cell high", 16'h1068, CELL_HIGH_LIMIT);
		chk("safe volt", 16'h4268, SAFETY_VOLT);
		chk("cell high rel", 8'h64, CELL_HIGH_RELEASE);
		chk("sensor prechg", 2'b11, {INT_SENSOR, PRECHG_CTRL});
		rdr(pgcb_pkg::IDX_MISC); chk("misc rsv", 32'h82, rd);
		$display("test limits done");
	endtask : t_limits
	// LEDs while charging and FET control
	task automatic t_misc;
		@(posedge CLK) DISCHARGING <= 0;
		cyc(2); chk("led off", 0, LED_ENABLE);
		wr(pgcb_pkg::IDX_MISC, 32'h04);
		cyc(1); chk("led on", 1, LED_ENABLE);
		@(posedge CLK) {FET_CHG_REQ, FET_DSG_REQ, OVERTEMP} <= 3'b111;
		cyc(4); chk("fets ot", 2'b01, {CHG_FET_ON, DSG_FET_ON});
		wr(pgcb_pkg::IDX_MISC, 32'h08);
		cyc(4); chk("dsg ot", 0, DSG_FET_ON);
		@(posedge CLK) OVERTEMP <= 0;
		wr(pgcb_pkg::IDX_MISC, 32'h01);
		@(posedge CLK) FET_CHG_REQ <= 0;
		cyc(6); chk("fet held", 1, CHG_FET_ON);
		cyc(10); chk("fet late", 0, CHG_FET_ON);
		$display("test misc done");
	endtask : t_misc
	// sleep on idle bus, integrity failure
	task automatic t_sleep;
		@(posedge CLK) hold <= 1;
		cyc(12); chk("not yet", 0, SLEEP);
		cyc(14); chk("asleep", 1, SLEEP);
		@(posedge CLK) hold <= 0;
		cyc(3); chk("awake", 0, SLEEP);
		wr(pgcb_pkg::IDX_MISC, 32'h30);
		@(posedge CLK) hold <= 1;
		cyc(40); chk("no sleep", 0, SLEEP);
		@(posedge CLK) hold <= 0;
		wr(pgcb_pkg::IDX_FAIL_LIMIT, 32'h2);
		chk("no ticks", 0, n_tick);
		wr(pgcb_pkg::IDX_CHECK_PER, 32'h1);
		@(posedge CLK) CHECK_FAIL <= 1;
		for (int i = 0; i < 40 && FAIL_FLAG !== 1'b1; i++) cyc(1);
		chk("fail flag", 1, FAIL_FLAG);
		chk("safe out", 1, SAFE_OUT);
		wr(pgcb_pkg::IDX_MISC, 32'h00);
		cyc(1); chk("safe off", 0, SAFE_OUT);
		$display("test sleep done");
	endtask : t_sleep
	initial begin
		repeat (16) @(posedge CLK);
		RST <= 0;
		t_reset();
		t_pack();
		t_bcast();
		t_gauge();
		t_limits();
		t_misc();
		t_sleep();
		test_done();
	end
endmodule : testbench
